// File: hw/stat_pkg.sv
// Purpose: shared constants of the statistics counter readout block
// Assumes: byte-wide register port, five switch ports
// Notes:   offsets are byte register numbers on the register port
package stat_pkg;
  // register port offsets
  localparam logic [7:0] CTRL_OFS  = 8'h6E;
  localparam logic [7:0] ADDR_OFS  = 8'h6F;
  localparam logic [7:0] BYTE4_OFS = 8'h74;
  localparam logic [7:0] BYTE3_OFS = 8'h75;
  localparam logic [7:0] BYTE2_OFS = 8'h76;
  localparam logic [7:0] BYTE1_OFS = 8'h77;
  localparam logic [7:0] BYTE0_OFS = 8'h78;
  localparam logic [7:0] BYTE_RST  = 8'h00;
  // control bits 7:1 select a counter read, bit 0 is address bit 8
  localparam logic [6:0] CTRL_READ_SEL = 7'h0E;
  // counter array shape
  localparam int PORTS    = 5;
  localparam int PER_PORT = 32;
  localparam int CNT_W    = 30;
  localparam int OCT_W    = 36;
  localparam int DROP_W   = 16;
  localparam int LEN_W    = 14;
  localparam int WORD_W   = 40;
  // word layout
  localparam int OVF_BIT   = 38;
  localparam int VALID_BIT = 37;
  // all-port range
  localparam logic [8:0] ALL_BASE = 9'h100;
  localparam logic [8:0] ALL_LAST = 9'h113;
  // 64-octet receive frame counter
  localparam logic [4:0]  RX64_OFS = 5'h0D;
  localparam logic [13:0] RX64_LEN = 14'h0040;
endpackage

// File: hw/indirect_port.sv
// Purpose: indirect control, address and data byte registers
// Assumes: register accesses are single-cycle strobes on clk_in
// Notes:   the data bytes are a snapshot taken on the trigger write
`timescale 1ns/100ps
module indirect_port (
  input  wire logic        clk_in,      // core clock
  input  wire logic        rst_in,      // sync reset, high
  input  wire logic        ce_in,       // clock enable
  input  wire logic [7:0]  reg_addr_in, // register offset
  input  wire logic [7:0]  reg_wdata_in,// write data
  input  wire logic        reg_wr_in,   // write strobe
  input  wire logic        reg_rd_in,   // read strobe
  input  wire logic [39:0] word_in,     // addressed counter word
  output logic      [7:0]  reg_rdata_out,// read data, registered
  output logic             trig_out,    // capture pulse
  output logic      [8:0]  cnt_addr_out // counter address
);
  typedef struct packed {
    logic [7:0]  ctrl;
    logic [7:0]  addr_low;
    logic [39:0] data;
    logic [7:0]  rdata;
  } port_state_type;

  port_state_type st_r;
  port_state_type st_nxt;

  // a low-address write under the read selection starts the capture
  assign trig_out = ce_in && reg_wr_in && (reg_addr_in == stat_pkg::ADDR_OFS)
                    && (st_r.ctrl[7:1] == stat_pkg::CTRL_READ_SEL);
  assign cnt_addr_out = {st_r.ctrl[0], reg_wdata_in};
  assign reg_rdata_out = st_r.rdata;

  // register writes, snapshot, read mux
  always_comb begin
    st_nxt = st_r;
    if (reg_wr_in && reg_addr_in == stat_pkg::CTRL_OFS) begin
      st_nxt.ctrl = reg_wdata_in;
    end else if (reg_wr_in && reg_addr_in == stat_pkg::ADDR_OFS) begin
      st_nxt.addr_low = reg_wdata_in;
    end
    if (trig_out) begin
      st_nxt.data = word_in;
    end
    // reads have no side effect, so partial byte reads are safe
    if (reg_rd_in) begin
      if (reg_addr_in == stat_pkg::CTRL_OFS) begin
        st_nxt.rdata = st_r.ctrl;
      end else if (reg_addr_in == stat_pkg::ADDR_OFS) begin
        st_nxt.rdata = st_r.addr_low;
      end else if (reg_addr_in == stat_pkg::BYTE4_OFS) begin
        st_nxt.rdata = st_r.data[39:32];
      end else if (reg_addr_in == stat_pkg::BYTE3_OFS) begin
        st_nxt.rdata = st_r.data[31:24];
      end else if (reg_addr_in == stat_pkg::BYTE2_OFS) begin
        st_nxt.rdata = st_r.data[23:16];
      end else if (reg_addr_in == stat_pkg::BYTE1_OFS) begin
        st_nxt.rdata = st_r.data[15:8];
      end else if (reg_addr_in == stat_pkg::BYTE0_OFS) begin
        st_nxt.rdata = st_r.data[7:0];
      end else begin
        st_nxt.rdata = stat_pkg::BYTE_RST; // unmapped reads as zero
      end
    end
  end

  // state register
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      st_r <= '0;
    end else if (ce_in) begin
      st_r <= st_nxt;
    end
  end

  snapshot_a: assert property (@(posedge clk_in) disable iff (rst_in)
    trig_out |=> st_r.data == $past(word_in))
    else $error("data bytes do not hold the captured word");
endmodule // indirect_port

// File: hw/stat_counter_bank.sv
// Purpose: per-port and all-port statistics counters with indirect readout
// Assumes: event inputs are one-cycle pulses synchronous to CLK_IN
// Notes:   every counter is cleared when the host captures it
`timescale 1ns/100ps
module stat_counter_bank (
  input  wire logic         CLK_IN,            // 20 MHz core clock
  input  wire logic         SYS_RST_IN,        // sync reset, high
  input  wire logic         CE_IN,             // clock enable
  input  wire logic [7:0]   REG_ADDR_IN,       // register offset
  input  wire logic [7:0]   REG_WDATA_IN,      // write data
  input  wire logic         REG_WR_IN,         // write strobe
  input  wire logic         REG_RD_IN,         // read strobe
  output logic      [7:0]   REG_RDATA_OUT,     // read data, registered
  input  wire logic [159:0] STAT_EVENT_IN,     // per-port counter pulses
  input  wire logic [4:0]   RX_FRAME_END_IN,   // rx frame done, per port
  input  wire logic [69:0]  RX_FRAME_LEN_IN,   // rx frame octets
  input  wire logic [4:0]   TX_FRAME_END_IN,   // tx frame done, per port
  input  wire logic [4:0]   TX_FRAME_GOOD_IN,  // tx frame good
  input  wire logic [69:0]  TX_FRAME_LEN_IN,   // tx frame octets
  input  wire logic [4:0]   RX_DROP_IN,        // rx frame dropped
  input  wire logic [4:0]   TX_DROP_IN,        // tx frame dropped
  input  wire logic [4:0]   FLUSH_IN,          // per-port flush level
  input  wire logic [4:0]   FREEZE_IN          // per-port freeze level
);
  typedef struct packed {
    logic [4:0][31:0][29:0] pcnt;
    logic [4:0][31:0]       pov;
    logic [4:0][1:0][35:0]  bcnt;
    logic [4:0][1:0]        bov;
    logic [4:0][1:0][15:0]  dcnt;
    logic [4:0][1:0]        dov;
  } cnt_state_type;

  cnt_state_type st_r;
  cnt_state_type st_nxt;
  logic          trig;
  logic [8:0]    cap_addr;
  logic [39:0]   cap_word;
  logic [4:0]    rx64;

  // sum with wrap at width w; bit 36 of the result is the carry out
  function automatic logic [36:0] add_carry(input logic [35:0] a,
                                            input logic [35:0] b,
                                            input int          w);
    logic [36:0] s;
    logic [36:0] m;
    s = {1'b0, a} + {1'b0, b};
    m = (37'h1 << w) - 37'h1;
    add_carry = {s[w], 36'(s & m)};
  endfunction

  // true for an address inside the per-port range
  function automatic logic is_port_addr(input logic [8:0] a);
    is_port_addr = !a[8] && (a[7:5] < 3'(stat_pkg::PORTS));
  endfunction

  // true for an address inside the all-port range
  function automatic logic is_all_addr(input logic [8:0] a);
    is_all_addr = (a >= stat_pkg::ALL_BASE) && (a <= stat_pkg::ALL_LAST);
  endfunction

  // formats the addressed counter; unmapped addresses give all zeros
  function automatic logic [39:0] build_word(input cnt_state_type s,
                                             input logic [8:0]    a);
    logic [39:0] w;
    logic [2:0]  p;
    w = '0;
    p = a[7:5];
    if (is_port_addr(a)) begin
      w[stat_pkg::OVF_BIT]   = s.pov[p][a[4:0]];
      w[stat_pkg::VALID_BIT] = 1'b1;
      w[29:0]                = s.pcnt[p][a[4:0]];
    end else if (is_all_addr(a)) begin
      p = a[4:2];
      w[stat_pkg::VALID_BIT] = 1'b1;
      if (!a[1]) begin
        w[stat_pkg::OVF_BIT] = s.bov[p][a[0]];
        w[35:0]              = s.bcnt[p][a[0]];
      end else begin
        w[stat_pkg::OVF_BIT] = s.dov[p][a[0]];
        w[15:0]              = s.dcnt[p][a[0]];
      end
    end
    build_word = w;
  endfunction

  // host-facing byte registers
  indirect_port indirect_port_inst (
    .clk_in        (CLK_IN),
    .rst_in        (SYS_RST_IN),
    .ce_in         (CE_IN),
    .reg_addr_in   (REG_ADDR_IN),
    .reg_wdata_in  (REG_WDATA_IN),
    .reg_wr_in     (REG_WR_IN),
    .reg_rd_in     (REG_RD_IN),
    .word_in       (cap_word),
    .reg_rdata_out (REG_RDATA_OUT),
    .trig_out      (trig),
    .cnt_addr_out  (cap_addr)
  );

  // word offered for capture in the trigger cycle itself
  assign cap_word = build_word(st_r, cap_addr);

  // 64-octet frames, bad ones included
  always_comb begin
    for (int p = 0; p < stat_pkg::PORTS; p++) begin
      rx64[p] = RX_FRAME_END_IN[p]
                && (RX_FRAME_LEN_IN[p*stat_pkg::LEN_W +: stat_pkg::LEN_W]
                    == stat_pkg::RX64_LEN);
    end
  end

  // clear on capture first, then count, so a same-cycle event survives
  always_comb begin
    cnt_state_type n;
    logic [36:0]   r;
    logic [2:0]    q;
    logic          inc;
    n   = st_r;
    r   = '0;
    q   = cap_addr[4:2];
    inc = 1'b0;
    if (trig && is_port_addr(cap_addr)) begin
      n.pcnt[cap_addr[7:5]][cap_addr[4:0]] = '0;
      n.pov[cap_addr[7:5]][cap_addr[4:0]]  = 1'b0;
    end else if (trig && is_all_addr(cap_addr)) begin
      if (!cap_addr[1]) begin
        n.bcnt[q][cap_addr[0]] = '0;
        n.bov[q][cap_addr[0]]  = 1'b0;
      end else begin
        n.dcnt[q][cap_addr[0]] = '0;
        n.dov[q][cap_addr[0]]  = 1'b0;
      end
    end
    for (int p = 0; p < stat_pkg::PORTS; p++) begin
      if (FLUSH_IN[p]) begin
        // flush is a level, so events during it are discarded
        n.pcnt[p] = '0;
        n.pov[p]  = '0;
        n.bcnt[p] = '0;
        n.bov[p]  = '0;
        n.dcnt[p] = '0;
        n.dov[p]  = '0;
      end else if (!FREEZE_IN[p]) begin
        for (int o = 0; o < stat_pkg::PER_PORT; o++) begin
          inc = (5'(o) == stat_pkg::RX64_OFS) ? rx64[p]
                                              : STAT_EVENT_IN[p*stat_pkg::PER_PORT + o];
          if (inc) begin
            r = add_carry(36'(n.pcnt[p][o]), 36'h1, stat_pkg::CNT_W);
            n.pcnt[p][o] = r[29:0];
            n.pov[p][o]  = n.pov[p][o] | r[36];
          end
        end
        if (RX_FRAME_END_IN[p]) begin
          r = add_carry(n.bcnt[p][0],
                        36'(RX_FRAME_LEN_IN[p*stat_pkg::LEN_W +: stat_pkg::LEN_W]),
                        stat_pkg::OCT_W);
          n.bcnt[p][0] = r[35:0];
          n.bov[p][0]  = n.bov[p][0] | r[36];
        end
        if (TX_FRAME_END_IN[p] && TX_FRAME_GOOD_IN[p]) begin
          r = add_carry(n.bcnt[p][1],
                        36'(TX_FRAME_LEN_IN[p*stat_pkg::LEN_W +: stat_pkg::LEN_W]),
                        stat_pkg::OCT_W);
          n.bcnt[p][1] = r[35:0];
          n.bov[p][1]  = n.bov[p][1] | r[36];
        end
        if (RX_DROP_IN[p]) begin
          r = add_carry(36'(n.dcnt[p][0]), 36'h1, stat_pkg::DROP_W);
          n.dcnt[p][0] = r[15:0];
          n.dov[p][0]  = n.dov[p][0] | r[36];
        end
        if (TX_DROP_IN[p]) begin
          r = add_carry(36'(n.dcnt[p][1]), 36'h1, stat_pkg::DROP_W);
          n.dcnt[p][1] = r[15:0];
          n.dov[p][1]  = n.dov[p][1] | r[36];
        end
      end
    end
    st_nxt = n;
  end

  // counter state; the clock enable freezes everything
  always_ff @(posedge CLK_IN) begin
    if (SYS_RST_IN) begin
      st_r <= '0;
    end else if (CE_IN) begin
      st_r <= st_nxt;
    end
  end

  // checks on the counting and readout paths
  ovf_set_a: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
    CE_IN && STAT_EVENT_IN[0] && !FLUSH_IN[0] && !FREEZE_IN[0] && !trig
    && (&st_r.pcnt[0][0]) |=> (st_r.pcnt[0][0] == '0) && st_r.pov[0][0])
    else $error("wrap did not set the overflow flag");

  valid_bit_a: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
    trig && (cap_addr > 9'h113) |-> cap_word == 40'h00_0000_0000)
    else $error("unmapped address returned a valid word");

  port_fmt_a: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
    trig && !cap_addr[8] && (cap_addr[7:5] < 3'h5)
    |-> cap_word[37] && (cap_word[36:30] == 7'h00) && !cap_word[39])
    else $error("per-port word format wrong");

  byte_fmt_a: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
    trig && (cap_addr == 9'h10D) |-> cap_word[37] && !cap_word[36]
    && (cap_word[35:0] == st_r.bcnt[3][1]))
    else $error("byte total word format wrong");

  drop_fmt_a: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
    trig && (cap_addr == 9'h112) |-> cap_word[37]
    && (cap_word[36:16] == 21'h00_0000) && (cap_word[15:0] == st_r.dcnt[4][0]))
    else $error("drop word format wrong");

  rx_total_a: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
    CE_IN && RX_FRAME_END_IN[1] && !FLUSH_IN[1] && !FREEZE_IN[1] && !trig
    |=> st_r.bcnt[1][0] == 36'($past(st_r.bcnt[1][0]) + $past(RX_FRAME_LEN_IN[27:14])))
    else $error("rx octet total missed a frame");

  tx_good_a: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
    CE_IN && !TX_FRAME_GOOD_IN[4] && !FLUSH_IN[4] && !trig
    |=> $stable(st_r.bcnt[4][1]))
    else $error("tx octet total counted a bad frame");

  drop_count_a: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
    CE_IN && TX_DROP_IN[0] && !FLUSH_IN[0] && !FREEZE_IN[0] && !trig
    |=> st_r.dcnt[0][1] == 16'($past(st_r.dcnt[0][1]) + 16'h0001))
    else $error("tx drop not counted");

  port_clear_a: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
    trig && (cap_addr == 9'h02D) && !rx64[1] && !FLUSH_IN[1]
    |=> (st_r.pcnt[1][13] == 30'h0000_0000) && !st_r.pov[1][13])
    else $error("per-port counter not cleared by capture");

  all_clear_a: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
    trig && (cap_addr == 9'h103) && !TX_DROP_IN[0]
    |=> st_r.dcnt[0][1] == 16'h0000)
    else $error("all-port counter not cleared by capture");

  flush_port_a: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
    CE_IN && FLUSH_IN[1] |=> (st_r.pcnt[1] == '0) && (st_r.pov[1] == '0)
    && (st_r.bov[1] == 2'h0) && (st_r.dcnt[1] == '0) && (st_r.bcnt[1] == '0))
    else $error("flush left a counter or flag set");

  freeze_hold_a: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
    CE_IN && FREEZE_IN[3] && !FLUSH_IN[3] && !trig
    |=> $stable(st_r.pcnt[3]) && $stable(st_r.bcnt[3]))
    else $error("frozen port kept counting");

  rx64_count_a: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
    CE_IN && rx64[0] && !FLUSH_IN[0] && !FREEZE_IN[0] && !trig
    |=> st_r.pcnt[0][13] == 30'($past(st_r.pcnt[0][13]) + 30'h0000_0001))
    else $error("64-octet frame not counted");

  ce_hold_a: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
    !CE_IN |=> $stable(st_r))
    else $error("state moved with clock enable low");

  // further counting, placement and capture checks on the exercised slots
  tx_total_a: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
    CE_IN && TX_FRAME_END_IN[3] && TX_FRAME_GOOD_IN[3] && !FLUSH_IN[3]
    && !FREEZE_IN[3] && !trig
    |=> st_r.bcnt[3][1] == 36'($past(st_r.bcnt[3][1]) + $past(TX_FRAME_LEN_IN[55:42])))
    else $error("tx octet total missed a good frame");

  rx_drop_a: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
    CE_IN && RX_DROP_IN[4] && !FLUSH_IN[4] && !FREEZE_IN[4] && !trig
    |=> st_r.dcnt[4][0] == 16'($past(st_r.dcnt[4][0]) + 16'h0001))
    else $error("rx drop not counted");

  event_count_a: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
    CE_IN && STAT_EVENT_IN[159] && !FLUSH_IN[4] && !FREEZE_IN[4] && !trig
    |=> st_r.pcnt[4][31] == 30'($past(st_r.pcnt[4][31]) + 30'h0000_0001))
    else $error("per-port event not counted");

  port_base_a: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
    trig && (cap_addr == 9'h09F) |-> cap_word[37]
    && (cap_word[29:0] == st_r.pcnt[4][31]))
    else $error("last port base or offset decoded wrong");

  all_base_a: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
    trig && (cap_addr == 9'h108) |-> cap_word[37]
    && (cap_word[35:0] == st_r.bcnt[2][0]))
    else $error("all-port address decoded wrong");

  drop_wrap_a: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
    CE_IN && RX_DROP_IN[0] && !FLUSH_IN[0] && !FREEZE_IN[0] && !trig
    && (st_r.dcnt[0][0] == 16'hFFFF) |=> st_r.dov[0][0] && (st_r.dcnt[0][0] == 16'h0000))
    else $error("drop wrap did not set the overflow flag");

  ovf_word_a: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
    trig && (cap_addr == 9'h102) |-> (cap_word[38] == st_r.dov[0][0])
    && (cap_word[15:0] == st_r.dcnt[0][0]))
    else $error("overflow flag missing from the word");

  ovf_clear_a: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
    trig && (cap_addr == 9'h102) && !RX_DROP_IN[0] && !FLUSH_IN[0]
    |=> !st_r.dov[0][0] && (st_r.dcnt[0][0] == 16'h0000))
    else $error("capture left the drop overflow flag set");

  frozen_read_a: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
    trig && (cap_addr == 9'h065) && FREEZE_IN[3] && !FLUSH_IN[3]
    |=> (st_r.pcnt[3][5] == 30'h0000_0000))
    else $error("frozen counter not cleared by capture");

  rx64_len_a: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
    CE_IN && RX_FRAME_END_IN[2] && (RX_FRAME_LEN_IN[41:28] != 14'h0040)
    && !FLUSH_IN[2] && !trig |=> $stable(st_r.pcnt[2][13]))
    else $error("64-octet counter took another length");

  port_word_a: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
    trig && (cap_addr == 9'h020) |-> (cap_word[29:0] == st_r.pcnt[1][0])
    && (cap_word[38] == st_r.pov[1][0]))
    else $error("per-port word lost its count");

  tx_drop_word_a: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
    trig && (cap_addr == 9'h103) |-> cap_word[37] && (cap_word[36:16] == 21'h00_0000)
    && (cap_word[15:0] == st_r.dcnt[0][1]))
    else $error("tx drop word format wrong");
endmodule // stat_counter_bank

// File: tb/host_model.sv
// Purpose: host side of the register port, reads counters indirectly
// Assumes: one access per strobe, launched 1 ns after a rising edge
// Notes:   strobes drop before the next access, so a write costs two cycles and a read three
`timescale 1ns/100ps
module host_model (
  input  wire logic       clk_in,    // core clock
  input  wire logic [7:0] rdata_in,  // register read data
  output logic      [7:0] addr_out,  // register offset
  output logic      [7:0] wdata_out, // write data
  output logic            wr_out,    // write strobe
  output logic            rd_out     // read strobe
);
  // bus idle until the first access
  initial begin
    addr_out = 8'h00;
    wdata_out = 8'h00;
    wr_out = 1'b0;
    rd_out = 1'b0;
  end
  // one write; strobe, address and data stand over one sampling edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_in);
    #1;
    addr_out = a;
    wdata_out = d;
    wr_out = 1'b1;
    @(posedge clk_in);
    #1;
    wr_out = 1'b0;
  endtask
  // one read; data is taken only after the answer edge has passed
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_in);
    #1;
    addr_out = a;
    rd_out = 1'b1;
    @(posedge clk_in);
    #1;
    rd_out = 1'b0;
    @(posedge clk_in);
    #1;
    d = rdata_in;
  endtask
  // select, trigger, then all five bytes top first; reads follow events
  // promptly, far inside the span in which a byte total can wrap
  task automatic read_word(input logic [8:0] a, output logic [39:0] w);
    logic [7:0] b;
    wr(stat_pkg::CTRL_OFS, {stat_pkg::CTRL_READ_SEL, a[8]});
    wr(stat_pkg::ADDR_OFS, a[7:0]);
    w = '0;
    for (int i = 0; i < 5; i++) begin
      rd(stat_pkg::BYTE4_OFS + 8'(i), b);
      w = {w[31:0], b};
    end
  endtask
  // drop counters: flags byte and the two low bytes are enough
  task automatic read_drop(input logic [8:0] a, output logic [39:0] w);
    logic [7:0] b4, b1, b0;
    wr(stat_pkg::CTRL_OFS, {stat_pkg::CTRL_READ_SEL, a[8]});
    wr(stat_pkg::ADDR_OFS, a[7:0]);
    rd(stat_pkg::BYTE4_OFS, b4);
    rd(stat_pkg::BYTE1_OFS, b1);
    rd(stat_pkg::BYTE0_OFS, b0);
    w = {b4, 16'h0000, b1, b0};
  endtask
endmodule // host_model

// File: tb/mib_statistics_counter_readout_tb.sv
// Purpose: self-checking bench of the statistics counter readout
// Assumes: an event held high counts once per cycle
// Notes:   the overflow case runs 65537 drop events, the bulk of the run
`timescale 1ns/100ps
module mib_statistics_counter_readout_tb;
  typedef struct {
    int         kind;
    int         port;
    int         off;
    int         len;
    int         n;
    logic [8:0] addr;
    int         cnt;
  } row_type;
  localparam int KEV = 0, KRX = 1, KTXG = 2, KTXB = 3, KRXD = 4, KTXD = 5;
  logic         clk = 1'b0, rst = 1'b1, ce = 1'b1;
  logic [7:0]   addr, wdata, rdata, b;
  logic         wr, rd;
  logic [159:0] ev = '0;
  logic [69:0]  rx_len = '0, tx_len = '0;
  logic [4:0]   rx_end = '0, tx_end = '0, tx_good = '0, rx_drop = '0, tx_drop = '0;
  logic [4:0]   flush = '0, freeze = '0;
  logic [39:0]  w;
  int           fails = 0;
  int           total_checks = 0;
  // kind, port, offset, length, events, address, expected count
  row_type rows [9] = '{
    '{KRX, 0, 0, 64, 3, 9'h00D, 3},
    '{KRX, 1, 0, 64, 2, 9'h02D, 2},
    '{KRX, 2, 0, 100, 2, 9'h108, 200},
    '{KTXG, 3, 0, 70, 2, 9'h10D, 140},
    '{KTXB, 4, 0, 70, 2, 9'h111, 0},
    '{KRXD, 4, 0, 0, 5, 9'h112, 5},
    '{KTXD, 0, 0, 0, 4, 9'h103, 4},
    '{KEV, 4, 31, 0, 3, 9'h09F, 3},
    '{KEV, 1, 0, 0, 7, 9'h020, 7}
  };
  always #25 clk = ~clk;
  stat_counter_bank stat_counter_bank_inst (
    .CLK_IN          (clk),
    .SYS_RST_IN      (rst),
    .CE_IN           (ce),
    .REG_ADDR_IN     (addr),
    .REG_WDATA_IN    (wdata),
    .REG_WR_IN       (wr),
    .REG_RD_IN       (rd),
    .REG_RDATA_OUT   (rdata),
    .STAT_EVENT_IN   (ev),
    .RX_FRAME_END_IN (rx_end),
    .RX_FRAME_LEN_IN (rx_len),
    .TX_FRAME_END_IN (tx_end),
    .TX_FRAME_GOOD_IN(tx_good),
    .TX_FRAME_LEN_IN (tx_len),
    .RX_DROP_IN      (rx_drop),
    .TX_DROP_IN      (tx_drop),
    .FLUSH_IN        (flush),
    .FREEZE_IN       (freeze)
  );
  host_model host_model_inst (
    .clk_in   (clk),
    .rdata_in (rdata),
    .addr_out (addr),
    .wdata_out(wdata),
    .wr_out   (wr),
    .rd_out   (rd)
  );
  // word as the host should see it: valid set, top bit always clear
  function automatic logic [39:0] exp_word(input logic ovf, input int cnt);
    exp_word = {1'b0, ovf, 1'b1, 37'(cnt)};
  endfunction
  task automatic chk40(input logic [39:0] got, input logic [39:0] exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] t=%0t value got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic end_test(input string name);
    $display("test %s done", name);
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // hold one event source high for n edges, then idle all of them
  task automatic pulse(input int kind, p, off, len, n);
    @(posedge clk);
    #1;
    case (kind)
      KEV: ev[p*32+off] = 1'b1;
      KRX: begin
        rx_end[p] = 1'b1;
        rx_len[p*14 +: 14] = 14'(len);
      end
      KTXG, KTXB: begin
        tx_end[p] = 1'b1;
        tx_good[p] = (kind == KTXG);
        tx_len[p*14 +: 14] = 14'(len);
      end
      KRXD: rx_drop[p] = 1'b1;
      default: tx_drop[p] = 1'b1;
    endcase
    repeat (n) @(posedge clk);
    #1;
    ev = '0;
    rx_end = '0;
    tx_end = '0;
    tx_good = '0;
    rx_drop = '0;
    tx_drop = '0;
  endtask
  // hang guard, about 85000 cycles against roughly 66000 planned
  initial begin
    #4250000;
    fails++;
    $display("[ERR] t=%0t watchdog expired", $time);
    finish_test();
  end
  // main sequence
  initial begin
    repeat (3) @(posedge clk);
    #1;
    rst = 1'b0;
    host_model_inst.rd(stat_pkg::BYTE4_OFS, b);
    chk40({32'h0, b}, {32'h0, stat_pkg::BYTE_RST});
    host_model_inst.rd(8'h10, b);
    chk40({32'h0, b}, 40'h00_0000_0000);
    end_test("reset");
    // each row counts, then is read twice to see the clear
    foreach (rows[i]) begin
      pulse(rows[i].kind, rows[i].port, rows[i].off, rows[i].len, rows[i].n);
      host_model_inst.read_word(rows[i].addr, w);
      chk40(w, exp_word(1'b0, rows[i].cnt));
      host_model_inst.read_word(rows[i].addr, w);
      chk40(w, exp_word(1'b0, 0));
    end
    end_test("table");
    // past the all-port range, and a trigger without the read select
    host_model_inst.read_word(9'h114, w);
    chk40(w, 40'h00_0000_0000);
    pulse(KEV, 0, 1, 0, 2);
    host_model_inst.wr(stat_pkg::CTRL_OFS, 8'h00);
    host_model_inst.wr(stat_pkg::ADDR_OFS, 8'h01);
    host_model_inst.rd(stat_pkg::BYTE0_OFS, b);
    chk40({32'h0, b}, 40'h00_0000_0000);
    host_model_inst.read_word(9'h001, w);
    chk40(w, exp_word(1'b0, 2));
    end_test("refusals");
    // frozen counter holds, stays readable and still clears on read
    pulse(KEV, 3, 5, 0, 2);
    freeze[3] = 1'b1;
    pulse(KEV, 3, 5, 0, 3);
    host_model_inst.read_word(9'h065, w);
    chk40(w, exp_word(1'b0, 2));
    host_model_inst.read_word(9'h065, w);
    chk40(w, exp_word(1'b0, 0));
    freeze[3] = 1'b0;
    // flush loses counts taken before and during it
    pulse(KEV, 1, 6, 0, 4);
    flush[1] = 1'b1;
    pulse(KEV, 1, 6, 0, 2);
    flush[1] = 1'b0;
    host_model_inst.read_word(9'h026, w);
    chk40(w, exp_word(1'b0, 0));
    ce = 1'b0;
    pulse(KEV, 0, 2, 0, 3);
    ce = 1'b1;
    host_model_inst.read_word(9'h002, w);
    chk40(w, exp_word(1'b0, 0));
    end_test("freeze flush");
    // one wrap of the 16-bit drop count plus one more event
    pulse(KRXD, 0, 0, 0, 65537);
    host_model_inst.read_drop(9'h102, w);
    chk40(w, exp_word(1'b1, 1));
    host_model_inst.read_word(9'h102, w);
    chk40(w, exp_word(1'b0, 0));
    end_test("overflow");
    // reset in mid-run clears the counters and the captured bytes
    pulse(KEV, 2, 3, 0, 2);
    rst = 1'b1;
    repeat (2) @(posedge clk);
    #1;
    rst = 1'b0;
    host_model_inst.rd(stat_pkg::BYTE4_OFS, b);
    chk40({32'h0, b}, {32'h0, stat_pkg::BYTE_RST});
    host_model_inst.read_word(9'h043, w);
    chk40(w, exp_word(1'b0, 0));
    end_test("mid reset");
    finish_test();
  end
endmodule // mib_statistics_counter_readout_tb
